// ### verilog/cen_notifier.sv
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cen_notifier
    import cen_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic capture_begin_event,
    input wire logic capture_finish_event,
    input wire logic image_open_event,
    input wire logic image_close_event,
    input wire logic accepted_image_trig,
    input wire logic rejected_image_trig,
    input wire logic image_dropped_event,
    input wire logic rejected_row_trig,
    input wire logic postponed_row_trig,
    input wire logic [NPIN-1:0] io_pin_level,
    input wire logic pin_three_pulse_begin,
    input wire logic pin_four_pulse_begin,
    input wire logic pin_five_pulse_begin,
    input wire logic pin_six_pulse_begin,
    input wire logic [STAMP_W-1:0] time_counter_reading,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic [TW-1:0] msg_type,
    output logic [STAMP_W-1:0] msg_stamp,
    output logic msg_legacy
);
    // Bus state.
    logic ack_q;
    logic [31:0] rdat_q;
    // Configuration.
    logic [TW-1:0] notify_type_index_q;
    logic [TW-1:0] counter_view_index_q;
    logic [1:0] pin_edge_choice_q [NPIN];
    logic [NPIN-1:0] pin_out_q;
    logic [1:0] notify_setting_q [NT];
    // Pin synchronisers and filtered level.
    logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    // Pending messages, their stamps and formats.
    logic [NT-1:0] pend_q;
    logic [STAMP_W-1:0] stamp_q [NT];
    logic [NT-1:0] leg_q;
    // Message slot towards the control channel.
    logic mv_q;
    logic [TW-1:0] mtype_q;
    logic [STAMP_W-1:0] mstamp_q;
    logic mleg_q;

    cen_tally_if tif ();

    // Bus decoding; every access is answered one cycle later.
    wire acc = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = acc && wb_we_i;
    wire wr_sel = wr && wb_adr_i == ADDR_NOTIFY_SEL && wb_sel_i[0];
    wire wr_set = wr && wb_adr_i == ADDR_NOTIFY_SET && wb_sel_i[0];
    wire wr_pin = wr && wb_adr_i == ADDR_PIN_CFG;
    wire wr_view = wr && wb_adr_i == ADDR_VIEW_SEL && wb_sel_i[0];
    wire wr_clr = wr && wb_adr_i == ADDR_TALLY;
    wire [1:0] set_wval = wb_dat_i[1:0];
    wire set_valid = set_wval != 2'h3;

    // Byte-lane merge of the pin configuration register.
    wire [11:0] pin_cur;
    wire [11:0] pin_mask = {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [11:0] pin_new = (pin_cur & ~pin_mask) | (wb_dat_i[11:0] & pin_mask);

    // Raw conditions from the rest of the camera.
    wire [NPIN-1:0] pin_evt;
    wire [NT-1:0] raw;
    assign raw[EV_CAP_BEGIN] = capture_begin_event; // RULE10
    assign raw[EV_CAP_FINISH] = capture_finish_event; // RULE11
    assign raw[EV_IMG_OPEN] = image_open_event; // RULE12
    assign raw[EV_IMG_CLOSE] = image_close_event; // RULE12
    assign raw[EV_ACC_IMG] = accepted_image_trig; // RULE13
    assign raw[EV_REJ_IMG] = rejected_image_trig; // RULE14
    assign raw[EV_DROPPED] = image_dropped_event; // RULE17
    assign raw[EV_REJ_ROW] = rejected_row_trig; // RULE15
    assign raw[EV_POST_ROW] = postponed_row_trig; // RULE16
    assign raw[EV_PIN1+NPIN-1:EV_PIN1] = pin_evt; // RULE1
    assign raw[EV_PULSE3] = pin_three_pulse_begin; // RULE2
    assign raw[EV_PULSE3+1] = pin_four_pulse_begin; // RULE2
    assign raw[EV_PULSE3+2] = pin_five_pulse_begin; // RULE2
    assign raw[EV_PULSE3+3] = pin_six_pulse_begin; // RULE2
    assign raw[EV_OVR] = 1'b0;

    // Per-line edge detection and configuration view.
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        wire agree = pin_s2_q[g] == pin_s3_q[g];
        wire rise = agree && pin_s3_q[g] && !pin_lvl_q[g];
        wire fall = agree && !pin_s3_q[g] && pin_lvl_q[g];
        wire [1:0] ch = pin_edge_choice_q[g];
        wire take = (ch == EDGE_UP) ? rise : (ch == EDGE_DOWN) ? fall : (rise || fall); // RULE8
        assign pin_evt[g] = take && !pin_out_q[g]; // RULE9
        assign pin_cur[PIN_EDGE_LSB+2*g +: 2] = pin_edge_choice_q[g];
        assign pin_cur[PIN_DIR_LSB+g] = pin_out_q[g];
    end

    // Which types may report, and what the occurrence of each does.
    wire [NT-1:0] enabled;
    wire [NT-1:0] legacy_now;
    for (genvar i = 0; i < NT; i++) begin : g_en
        assign enabled[i] = notify_setting_q[i] != SET_OFF; // RULE5
        assign legacy_now[i] = notify_setting_q[i] == SET_LEGACY; // RULE7
    end
    wire [NT-1:0] fire = raw & enabled; // RULE6

    // Arbiter: the highest pending index wins, so the overrun goes first.
    logic [TW-1:0] pick_idx;
    logic pick_any;
    always_comb begin
        pick_idx = '0;
        pick_any = 1'b0;
        for (int i = 0; i < NT; i++) begin
            if (pend_q[i]) begin
                pick_idx = TW'(i);
                pick_any = 1'b1;
            end
        end
    end
    wire load = pick_any && (!mv_q || msg_ready);
    wire [NT-1:0] drain = load ? ({{(NT-1){1'b0}}, 1'b1} << pick_idx) : '0;

    // A second occurrence while the first is still waiting overruns the queue.
    wire ovf = |(fire & pend_q & ~drain); // RULE3
    wire [NT-1:0] ovr_bit = {1'b1, {(NT-1){1'b0}}};
    // A new occurrence beats the drain of the same entry.
    wire [NT-1:0] pend_d = (pend_q & ~drain) | fire | (ovf ? ovr_bit : '0);

    // A selector past the last type reads as off rather than an unknown value.
    wire [1:0] set_rd = (notify_type_index_q < TW'(NT)) ?
        notify_setting_q[notify_type_index_q] : 2'h0;

    // Read selection; unmapped offsets read as zero.
    wire [31:0] rd_val =
        (wb_adr_i == ADDR_NOTIFY_SEL) ? {27'h0, notify_type_index_q} :
        (wb_adr_i == ADDR_NOTIFY_SET) ? {30'h0, set_rd} :
        (wb_adr_i == ADDR_PIN_CFG) ? {20'h0, pin_cur} :
        (wb_adr_i == ADDR_VIEW_SEL) ? {27'h0, counter_view_index_q} :
        (wb_adr_i == ADDR_TALLY) ? tif.tally :
        (wb_adr_i == ADDR_PENDING) ? {14'h0, pend_q} : 32'h0;

    // Counters see every condition, including the overrun itself.
    assign tif.hit = raw | (ovf ? ovr_bit : '0); // RULE21
    assign tif.view = counter_view_index_q; // RULE18
    assign tif.clr = wr_clr; // RULE20

    cen_tally u_tally (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    // Bus answer, registered.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            rdat_q <= acc ? rd_val : 32'h0;
        end
    end

    // Selectors and pin configuration.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            notify_type_index_q <= RST_SEL;
            counter_view_index_q <= RST_SEL;
            for (int g = 0; g < NPIN; g++) begin
                pin_edge_choice_q[g] <= RST_PIN_CFG[PIN_EDGE_LSB+2*g +: 2];
            end
            pin_out_q <= RST_PIN_CFG[PIN_DIR_LSB +: NPIN];
        end else begin
            if (wr_sel) notify_type_index_q <= wb_dat_i[TW-1:0];
            if (wr_view) counter_view_index_q <= wb_dat_i[TW-1:0];
            if (wr_pin) begin
                for (int g = 0; g < NPIN; g++) begin
                    pin_edge_choice_q[g] <= pin_new[PIN_EDGE_LSB+2*g +: 2];
                end
                pin_out_q <= pin_new[PIN_DIR_LSB +: NPIN];
            end
        end
    end

    // Settings: an overrun turns every type off and wins over a write,
    // so nothing comes back on until software writes it again.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NT; i++) notify_setting_q[i] <= RST_SETTING;
        end else if (ovf) begin
            for (int i = 0; i < NT; i++) notify_setting_q[i] <= SET_OFF; // RULE3 RULE4
        end else if (wr_set && set_valid && notify_type_index_q < TW'(NT)) begin
            notify_setting_q[notify_type_index_q] <= set_wval; // RULE5
        end
    end

    // Three-stage pin sampling; the level moves once stages two and three agree.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_lvl_q <= '0;
        end else begin
            pin_s1_q <= io_pin_level;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int g = 0; g < NPIN; g++) begin
                if (pin_s2_q[g] == pin_s3_q[g]) pin_lvl_q[g] <= pin_s3_q[g];
            end
        end
    end

    // Pending entries capture time and format at the moment they occur.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend_q <= '0;
            leg_q <= '0;
            for (int i = 0; i < NT; i++) stamp_q[i] <= '0;
        end else begin
            pend_q <= pend_d;
            for (int i = 0; i < NT; i++) begin
                if (fire[i] && !(pend_q[i] && !drain[i])) begin
                    stamp_q[i] <= time_counter_reading; // RULE19
                    leg_q[i] <= legacy_now[i]; // RULE7
                end
            end
            if (ovf) begin
                stamp_q[EV_OVR] <= time_counter_reading; // RULE19
                leg_q[EV_OVR] <= legacy_now[EV_OVR];
            end
        end
    end

    // Message slot: holds until the channel takes it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mv_q <= 1'b0;
            mtype_q <= '0;
            mstamp_q <= '0;
            mleg_q <= 1'b0;
        end else if (load) begin
            mv_q <= 1'b1;
            mtype_q <= pick_idx;
            mstamp_q <= stamp_q[pick_idx];
            mleg_q <= leg_q[pick_idx];
        end else if (msg_ready) begin
            mv_q <= 1'b0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign msg_valid = mv_q;
    assign msg_type = mtype_q;
    assign msg_stamp = mstamp_q;
    assign msg_legacy = mleg_q;

    property p_wb_ack;
        @(posedge sys_clk) disable iff (!rst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus answer not one cycle");

    property p_off_silent;
        @(posedge sys_clk) disable iff (!rst_n)
        (capture_begin_event && notify_setting_q[EV_CAP_BEGIN] == SET_OFF && !pend_q[0])
            |=> !pend_q[0];
    endproperty
    a_off_silent: assert property (p_off_silent) else $error("disabled type queued"); // RULE5

    property p_overrun;
        @(posedge sys_clk) disable iff (!rst_n)
        ovf |=> (pend_q[EV_OVR] && notify_setting_q[EV_CAP_BEGIN] == SET_OFF
            && notify_setting_q[EV_PIN1] == SET_OFF);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun did not disable"); // RULE3

    sequence s_held;
        msg_valid && !msg_ready;
    endsequence
    property p_msg_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        s_held |=> msg_valid && $stable(msg_type) && $stable(msg_stamp);
    endproperty
    a_msg_hold: assert property (p_msg_hold) else $error("message changed before taken"); // RULE6

    property p_out_pin;
        @(posedge sys_clk) disable iff (!rst_n)
        pin_out_q[0] |-> !raw[EV_PIN1];
    endproperty
    a_out_pin: assert property (p_out_pin) else $error("output line gave edge event"); // RULE9

    property p_stamp;
        @(posedge sys_clk) disable iff (!rst_n)
        (fire[0] && !pend_q[0]) |=> (stamp_q[0] == $past(time_counter_reading));
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp not taken at event"); // RULE19
endmodule
`default_nettype wire

// ### verilog/cen_pkg.sv
// Functional notes
// RULE1: Enabled input lines 1-4 report configured edges.
// RULE2: Enabled pulse starts on lines 3-6 report.
// RULE3: Queue overrun disables all events, reports once.
// RULE4: Host re-enables events; device keeps them off.
// RULE5: One setting per type, chosen by index.
// RULE6: Setting on reports every occurrence.
// RULE7: Legacy setting also reports, legacy format.
// RULE8: Per-line choice: rising, falling or either edge.
// RULE9: Edge choice for inputs; outputs report pulses.
// RULE10: Enabled capture begin is reported.
// RULE11: Enabled capture finish is reported.
// RULE12: Image open and image close are reported.
// RULE13: Accepted image trigger is reported.
// RULE14: Rejected image trigger reported, starts nothing.
// RULE15: Rejected row trigger reported, starts nothing.
// RULE16: Postponed row trigger reported instead.
// RULE17: Dropped image for lack of memory reported.
// RULE18: Tally per type, view chosen by index.
// RULE19: Each message stamped with 64-bit time.
// RULE20: Clear command zeroes only the viewed tally.
// RULE21: Tallies count always and saturate.
package cen_pkg;
    localparam int NT = 18;
    localparam int TW = 5;
    localparam int TALLY_W = 32;
    localparam int STAMP_W = 64;
    localparam int NPIN = 4;
    // Event type indices.
    localparam int EV_CAP_BEGIN = 0;
    localparam int EV_CAP_FINISH = 1;
    localparam int EV_IMG_OPEN = 2;
    localparam int EV_IMG_CLOSE = 3;
    localparam int EV_ACC_IMG = 4;
    localparam int EV_REJ_IMG = 5;
    localparam int EV_DROPPED = 6;
    localparam int EV_REJ_ROW = 7;
    localparam int EV_POST_ROW = 8;
    localparam int EV_PIN1 = 9;
    localparam int EV_PULSE3 = 13;
    localparam int EV_OVR = 17;
    // Notification settings.
    localparam logic [1:0] SET_OFF = 2'h0;
    localparam logic [1:0] SET_ON = 2'h1;
    localparam logic [1:0] SET_LEGACY = 2'h2;
    // Edge choices.
    localparam logic [1:0] EDGE_UP = 2'h0;
    localparam logic [1:0] EDGE_DOWN = 2'h1;
    localparam logic [1:0] EDGE_EITHER = 2'h2;
    // Register byte offsets.
    localparam logic [7:0] ADDR_NOTIFY_SEL = 8'h00;
    localparam logic [7:0] ADDR_NOTIFY_SET = 8'h04;
    localparam logic [7:0] ADDR_PIN_CFG = 8'h08;
    localparam logic [7:0] ADDR_VIEW_SEL = 8'h0C;
    localparam logic [7:0] ADDR_TALLY = 8'h10;
    localparam logic [7:0] ADDR_PENDING = 8'h14;
    // Field positions in the pin configuration register.
    localparam int PIN_EDGE_LSB = 0;
    localparam int PIN_DIR_LSB = 8;
    // Reset values and the tally saturation limit.
    localparam logic [11:0] RST_PIN_CFG = 12'h000;
    localparam logic [4:0] RST_SEL = 5'h00;
    localparam logic [1:0] RST_SETTING = 2'h0;
    localparam logic [TALLY_W-1:0] TALLY_MAX = 32'hFFFFFFFF;
endpackage

// ### verilog/cen_tally_if.sv
`timescale 1ns/1ps
`default_nettype none
// Occurrence pulses in, viewed tally out.
interface cen_tally_if;
    import cen_pkg::*;
    logic [NT-1:0] hit;
    logic [TW-1:0] view;
    logic clr;
    logic [TALLY_W-1:0] tally;
    modport core (output hit, output view, output clr, input tally);
    modport cnt (input hit, input view, input clr, output tally);
endinterface
`default_nettype wire

// ### verilog/cen_tally.sv
`timescale 1ns/1ps
`default_nettype none
module cen_tally
    import cen_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    cen_tally_if.cnt tif
);
    logic [TALLY_W-1:0] cnt_q [NT];

    // Saturating counters; a clear on the viewed entry beats a hit.
    for (genvar i = 0; i < NT; i++) begin : g_cnt
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                cnt_q[i] <= '0;
            end else if (tif.clr && tif.view == TW'(i)) begin
                cnt_q[i] <= '0; // RULE20
            end else if (tif.hit[i] && cnt_q[i] != TALLY_MAX) begin
                cnt_q[i] <= cnt_q[i] + 1'b1; // RULE21
            end
        end
    end

    // Out-of-range view reads as zero.
    assign tif.tally = (tif.view < TW'(NT)) ? cnt_q[tif.view] : '0; // RULE18

    property p_clr_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        (tif.clr && tif.view == 5'h00) |=> (cnt_q[0] == '0);
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("tally clear ignored"); // RULE20

    property p_saturate;
        @(posedge sys_clk) disable iff (!rst_n)
        (cnt_q[1] == TALLY_MAX && !(tif.clr && tif.view == 5'h01)) |=> (cnt_q[1] == TALLY_MAX);
    endproperty
    a_saturate: assert property (p_saturate) else $error("tally wrapped"); // RULE21
endmodule
`default_nettype wire

// ### test/cen_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host end of the control channel: takes messages, stalls at random or on demand.
module cen_host_model
    import cen_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic msg_valid,
    input wire logic [TW-1:0] msg_type,
    input wire logic [STAMP_W-1:0] msg_stamp,
    input wire logic msg_legacy,
    output logic msg_ready
);
    logic [TW-1:0] seen_type[$];
    logic [STAMP_W-1:0] seen_stamp[$];
    logic seen_leg[$];
    // Ready moves only after an edge; a message is logged at the edge that takes it.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            msg_ready <= 1'b0;
        end else begin
            msg_ready <= !stall && ($urandom_range(3) != 0);
            if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
                seen_type.push_back(msg_type);
                seen_stamp.push_back(msg_stamp);
                seen_leg.push_back(msg_legacy);
            end
        end
    end
endmodule
`default_nettype wire

// ### test/camera_event_notifier_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module camera_event_notifier_tb_top;
    import cen_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [8:0] ev = 9'h000;
    logic [3:0] pul = 4'h0;
    logic [3:0] pins = 4'h0;
    logic [63:0] tcnt = 64'h0;
    logic stall = 1'b0;
    logic msg_ready, msg_valid, msg_legacy;
    logic [TW-1:0] msg_type;
    logic [STAMP_W-1:0] msg_stamp;
    logic [31:0] r;
    logic [11:0] pcfg;
    logic [1:0] s;
    logic [63:0] last_stamp;
    int exp_t[$];
    logic exp_l[$];
    logic [63:0] exp_s[$];
    int errors = 0;
    int comparisons = 0;
    int seed_v;

    // Free-running clock and stamp counter.
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) tcnt <= tcnt + 64'h1;

    cen_notifier u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .capture_begin_event(ev[0]), .capture_finish_event(ev[1]),
        .image_open_event(ev[2]), .image_close_event(ev[3]), .accepted_image_trig(ev[4]),
        .rejected_image_trig(ev[5]), .image_dropped_event(ev[6]),
        .rejected_row_trig(ev[7]), .postponed_row_trig(ev[8]), .io_pin_level(pins),
        .pin_three_pulse_begin(pul[0]), .pin_four_pulse_begin(pul[1]),
        .pin_five_pulse_begin(pul[2]), .pin_six_pulse_begin(pul[3]),
        .time_counter_reading(tcnt), .msg_ready(msg_ready), .msg_valid(msg_valid),
        .msg_type(msg_type), .msg_stamp(msg_stamp), .msg_legacy(msg_legacy));

    cen_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
        .msg_valid(msg_valid), .msg_type(msg_type), .msg_stamp(msg_stamp),
        .msg_legacy(msg_legacy), .msg_ready(msg_ready));

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task end_sim;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Classic single cycle: held until ack is sampled high, released at that edge.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 50) errors++;
    endtask

    task automatic set_notify(input int i, input logic [1:0] v);
        wb(1'b1, ADDR_NOTIFY_SEL, i);
        wb(1'b1, ADDR_NOTIFY_SET, {30'h0, v});
    endtask

    task automatic tally(input int i);
        wb(1'b1, ADDR_VIEW_SEL, i);
        wb(1'b0, ADDR_TALLY, 32'h0);
    endtask

    // One-cycle pulses; the stamp the design should sample is the counter in that cycle.
    task automatic fire(input logic [8:0] e, input logic [3:0] p);
        @(posedge sys_clk);
        ev <= e;
        pul <= p;
        #1 last_stamp = tcnt;
        @(posedge sys_clk);
        ev <= 9'h000;
        pul <= 4'h0;
    endtask

    task automatic push_exp(input int t, input logic leg);
        exp_t.push_back(t);
        exp_l.push_back(leg);
        exp_s.push_back(last_stamp);
    endtask

    // Waits for the expected messages, then lets stray extras show up before comparing.
    task automatic expect_msgs(input bit with_stamp);
        int n;
        n = 0;
        while (u_host.seen_type.size() < exp_t.size() && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (20) @(posedge sys_clk);
        chk("msg_count", u_host.seen_type.size(), exp_t.size());
        foreach (exp_t[k]) begin
            if (k < u_host.seen_type.size()) begin
                chk("msg_type", u_host.seen_type[k], exp_t[k]);
                chk("msg_legacy", u_host.seen_leg[k], exp_l[k]);
                if (with_stamp) chk("msg_stamp", u_host.seen_stamp[k], exp_s[k]);
            end
        end
        exp_t.delete();
        exp_l.delete();
        exp_s.delete();
        u_host.seen_type.delete();
        u_host.seen_stamp.delete();
        u_host.seen_leg.delete();
    endtask

    function automatic bit edge_hits(input logic [1:0] choice, input bit rise);
        if (choice == EDGE_UP) return rise;
        if (choice == EDGE_DOWN) return !rise;
        return 1'b1;
    endfunction

    // Watchdog against a hung handshake.
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        end_sim();
    end

    initial begin
        seed_v = $urandom(32'h2020dbb2);
        tcnt <= {$urandom, $urandom};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        wb(1'b0, ADDR_PENDING, 32'h0);
        chk("pending_rst", r, 32'h0);
        wb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", r, 32'h0);
        chk("valid_rst", msg_valid, 1'b0);
        // Each plain event, on or legacy at random, then off but still counted.
        for (int i = 0; i < 9; i++) begin
            s = ($urandom_range(1) == 1) ? SET_LEGACY : SET_ON;
            set_notify(i, s);
            fire(9'h001 << i, 4'h0);
            push_exp(i, s == SET_LEGACY);
            expect_msgs(1'b1);
            set_notify(i, SET_OFF);
            fire(9'h001 << i, 4'h0);
            expect_msgs(1'b0);
            tally(i);
            chk("tally", r, 32'h2);
        end
        wb(1'b1, ADDR_TALLY, 32'h0);
        wb(1'b0, ADDR_TALLY, 32'h0);
        chk("tally_clr", r, 32'h0);
        tally(7);
        chk("tally_other", r, 32'h2);
        tally(20);
        chk("tally_none", r, 32'h0);
        // A setting write with no byte lane enabled must leave the type off.
        wb_sel <= 4'h0;
        wb(1'b1, ADDR_NOTIFY_SET, {30'h0, SET_ON});
        wb_sel <= 4'hF;
        fire(9'h100, 4'h0);
        expect_msgs(1'b0);
        // Random edge choices and directions on the four lines.
        pcfg = $urandom;
        wb(1'b1, ADDR_PIN_CFG, {20'h0, pcfg});
        for (int g = 0; g < 4; g++) begin
            set_notify(EV_PIN1 + g, SET_ON);
            set_notify(EV_PULSE3 + g, SET_ON);
        end
        for (int e = 0; e < 2; e++) begin
            @(posedge sys_clk);
            pins <= (e == 0) ? 4'hF : 4'h0;
            for (int g = 3; g >= 0; g--) begin
                if (!pcfg[8+g] && edge_hits(pcfg[2*g+:2], e == 0)) push_exp(EV_PIN1 + g, 1'b0);
            end
            expect_msgs(1'b0);
        end
        fire(9'h000, 4'hF);
        for (int g = 3; g >= 0; g--) push_exp(EV_PULSE3 + g, 1'b0);
        expect_msgs(1'b1);
        // Three quick occurrences against a stalled host overflow the queue.
        stall <= 1'b1;
        set_notify(EV_CAP_BEGIN, SET_ON);
        repeat (3) fire(9'h001, 4'h0);
        push_exp(EV_CAP_BEGIN, 1'b0);
        push_exp(EV_OVR, 1'b0);
        push_exp(EV_CAP_BEGIN, 1'b0);
        @(posedge sys_clk);
        stall <= 1'b0;
        expect_msgs(1'b0);
        fire(9'h001, 4'h1);
        expect_msgs(1'b0);
        set_notify(EV_CAP_BEGIN, SET_ON);
        fire(9'h001, 4'h0);
        push_exp(EV_CAP_BEGIN, 1'b0);
        expect_msgs(1'b1);
        tally(EV_OVR);
        chk("tally_ovr", r, 32'h1);
        // A setting code of three is refused, so the selected type stays on.
        wb(1'b1, ADDR_NOTIFY_SET, 32'h3);
        wb(1'b0, ADDR_NOTIFY_SET, 32'h0);
        chk("set_refused", r, {30'h0, SET_ON});
        end_sim();
    end
endmodule
`default_nettype wire
